//--- crs_clock_reset_seq.v
// Clock source selection and reset sequencing with a Wishbone register slave
// Overview of operation
// - Every reset reloads the RC trim register with FFh.
// - Trim code 00h gives the fastest RC, FFh the slowest.
// - Main PLL, enabled by option, multiplies 1MHz reference by 4 or 8.
// - PLL off, RC on: oscillator clock is the 1MHz RC output.
// - PLL and RC both off: oscillator clock comes from external input.
// - PLL clock is withheld for a start-up delay after each start.
// - Lock flag sets when PLL output reaches operating frequency.
// - Control bit 1 enables clock output pin; clear frees it for GPIO.
// - Control bit 0 selects CPU clock: oscillator, or oscillator over 32.
// - Both control bits clear on reset; upper six bits read zero.
// - Pin driven low from pin, voltage detector or watchdog, and through delay.
// - After reset the vector is fetched from FFFEh-FFFFh.
// - Reset runs active phase, counted delay, then vector fetch, in order.
// - Delay is 256 cycles for RC or external clock, 4096 for crystal.
// - Vector fetch phase lasts exactly two clock cycles.
// - With PLL enabled, add PLL start-up delay before clock after reset.
// - Reset pin is input and open-drain output with weak pull-up.
// - External reset is detected asynchronously, even without a clock.
// - Crystal oscillator keeps running during the reset phase.
// - Timer PLL multiplies mandatory 8MHz input by 4.
// - Without the multi-oscillator, the default port pin is the clock input.
// - Lock flag is bit 3 of the status register, hardware only.
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "crs_seq_regs.vh"
module crs_clock_reset_seq #(
	parameter PLL_STARTUP_CYCLES = `CRS_PLL_STARTUP_US * `CRS_CLK_MHZ,
	parameter LONG_DELAY = `CRS_DELAY_LONG
) (
	// System
	input wire clk,
	input wire nrst,
	// Wishbone slave
	input wire wbCyc,
	input wire wbStb,
	input wire wbWe,
	input wire [7:0] wbAdr,
	input wire [3:0] wbSel,
	input wire [31:0] wbDatI,
	output reg [31:0] wbDatO,
	output reg wbAck,
	// Option bits
	input wire rcEnable,
	input wire pllEnable,
	input wire pllTimes8,
	input wire xtalSelect,
	input wire multiOscUsed,
	input wire timerPllEnable,
	// Reset sources
	input wire lowVoltageReset,
	input wire watchdogReset,
	input wire resetPinIn,
	output reg resetPinOut,
	output reg resetPinOe,
	// Clocking
	input wire pllLockRaw,
	output reg [7:0] trimBits,
	output reg [1:0] oscSource,
	output reg pllMultiply8,
	output reg pllRun,
	output reg pllClockGate,
	output reg timerPllRun,
	output reg defaultExtClockPin,
	output reg xtalRun,
	output reg cpuClockEnable,
	output reg clockOutEnable,
	// Core side
	output reg cpuResetN,
	output reg vectorFetch,
	output reg [15:0] vectorAddr
);
	localparam ST_ACTIVE = 3'h0;
	localparam ST_DELAY = 3'h1;
	localparam ST_PLLWAIT = 3'h2;
	localparam ST_FETCH = 3'h3;
	localparam ST_RUN = 3'h4;

	// ****************************************
	// Decoding helpers
	// ****************************************
	// High in the phases that keep the reset pin pulled low
	function inPinPhase;
		input [2:0] st;
		begin
			inPinPhase = (st == ST_ACTIVE) | (st == ST_DELAY);
		end
	endfunction
	// High once the core fetches its vector or runs
	function inCorePhase;
		input [2:0] st;
		begin
			inCorePhase = (st == ST_FETCH) | (st == ST_RUN);
		end
	endfunction
	// Last count of the stabilisation delay for the chosen source
	function [31:0] delayLast;
		input xtal;
		begin
			if (xtal) begin
				delayLast = LONG_DELAY - 1;
			end else begin
				delayLast = `CRS_DELAY_SHORT - 32'h1;
			end
		end
	endfunction
	// End of the PLL start-up wait
	function pllWaitDone;
		input [31:0] cnt;
		begin
			pllWaitDone = (cnt >= PLL_STARTUP_CYCLES - 1);
		end
	endfunction
	// Register select from the byte address
	function isReg;
		input [7:0] adr;
		input [7:0] want;
		begin
			isReg = (adr == want);
		end
	endfunction
	// Oscillator source from the option bits: crystal, RC or external input
	function [1:0] oscSelect;
		input rc;
		input xtal;
		begin
			if (xtal) begin
				oscSelect = `CRS_SRC_XTAL;
			end else if (rc) begin
				oscSelect = `CRS_SRC_RC;
			end else begin
				oscSelect = `CRS_SRC_EXT;
			end
		end
	endfunction

	// ****************************************
	// Asynchronous reset merge
	// ****************************************
	// The pin reads low while we pull it ourselves, so it only counts while released
	wire intResetN = nrst & ~lowVoltageReset & ~watchdogReset;
	wire pinResetN = resetPinIn | resetPinOe;
	wire anyResetN = intResetN & pinResetN;
	reg [1:0] rstSync_q;
	always @(posedge clk or negedge anyResetN) begin
		if (!anyResetN) begin
			rstSync_q <= 2'b00;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	wire seqResetN = rstSync_q[1];

	// ****************************************
	// Lock input synchroniser
	// ****************************************
	reg [2:0] lockSync_q;
	reg locked_q;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lockSync_q <= 3'h0;
			locked_q <= 1'b0;
		end else begin
			lockSync_q <= {lockSync_q[1:0], pllLockRaw};
			// A change counts once the last two stages agree
			if (lockSync_q[2] == lockSync_q[1]) begin
				locked_q <= lockSync_q[2] & pllEnable;
			end
		end
	end

	// ****************************************
	// Reset sequencer
	// ****************************************
	reg [2:0] state_q;
	reg [31:0] count_q;
	reg [1:0] fetchCnt_q;
	always @(posedge clk or negedge seqResetN) begin
		if (!seqResetN) begin
			state_q <= ST_ACTIVE;
			count_q <= 32'h0;
			fetchCnt_q <= 2'h0;
		end else begin
			case (state_q)
				ST_ACTIVE: begin
					state_q <= ST_DELAY;
					count_q <= 32'h0;
				end
				// Counted delay lets the oscillator settle before the core runs
				ST_DELAY: begin
					count_q <= count_q + 32'h1;
					if (count_q == delayLast(xtalSelect)) begin
						count_q <= 32'h0;
						state_q <= pllEnable ? ST_PLLWAIT : ST_FETCH;
					end
				end
				ST_PLLWAIT: begin
					count_q <= count_q + 32'h1;
					if (pllWaitDone(count_q)) begin
						state_q <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					fetchCnt_q <= fetchCnt_q + 2'h1;
					if (fetchCnt_q == `CRS_FETCH_CYCLES - 2'h1) begin
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					state_q <= ST_RUN;
				end
				default: begin
					state_q <= ST_ACTIVE;
				end
			endcase
		end
	end

	// ****************************************
	// Registers and Wishbone slave
	// ****************************************
	reg [1:0] ctrl_q;
	reg [7:0] trim_q;
	wire wbHit = wbCyc & wbStb & ~wbAck;
	// Writes land at the edge at which the master samples ack high
	wire wbWrite = wbCyc & wbStb & wbAck & wbWe & wbSel[0];
	always @(posedge clk or negedge seqResetN) begin
		if (!seqResetN) begin
			ctrl_q <= 2'b00;
			trim_q <= `CRS_RC_TRIM_RESET;
			wbAck <= 1'b0;
			wbDatO <= 32'h0;
		end else begin
			wbAck <= wbHit;
			if (wbWrite) begin
				if (isReg(wbAdr, `CRS_MAIN_CLOCK_CTRL_ADDR)) begin
					ctrl_q <= wbDatI[1:0];
				end
				if (isReg(wbAdr, `CRS_RC_TRIM_ADDR)) begin
					trim_q <= wbDatI[7:0];
				end
			end
			if (wbHit & ~wbWe) begin
				case (wbAdr)
					`CRS_MAIN_CLOCK_CTRL_ADDR: wbDatO <= {30'h0, ctrl_q};
					`CRS_RC_TRIM_ADDR: wbDatO <= {24'h0, trim_q};
					`CRS_SYS_INTEGRITY_STATUS_ADDR: wbDatO <= {28'h0, locked_q, 3'h0};
					`CRS_OPTIONS_ADDR: wbDatO <= {24'h0, 2'h0, timerPllEnable, multiOscUsed,
						xtalSelect, pllTimes8, pllEnable, rcEnable};
					default: wbDatO <= 32'h0;
				endcase
			end else begin
				wbDatO <= 32'h0;
			end
		end
	end

	// ****************************************
	// Slow mode divider with boundary switch
	// ****************************************
	reg [4:0] div_q;
	reg slowActive_q;
	wire boundary = (div_q == 5'h1f);
	always @(posedge clk or negedge seqResetN) begin
		if (!seqResetN) begin
			div_q <= 5'h0;
			slowActive_q <= 1'b0;
		end else begin
			div_q <= div_q + 5'h1;
			// Mode change waits for the divider wrap
			if (boundary) begin
				slowActive_q <= ctrl_q[`CRS_SLOW_MODE_SELECT_BIT];
			end
		end
	end

	// ****************************************
	// Reset pin driver
	// ****************************************
	// Reset only by the internal sources, so a pin reset cannot lock itself in
	always @(posedge clk or negedge intResetN) begin
		if (!intResetN) begin
			resetPinOut <= 1'b0;
			resetPinOe <= 1'b1;
		end else if (!seqResetN) begin
			resetPinOut <= 1'b0;
			resetPinOe <= 1'b1;
		end else begin
			resetPinOut <= 1'b0;
			resetPinOe <= inPinPhase(state_q);
		end
	end

	// ****************************************
	// Core reset and vector fetch
	// ****************************************
	always @(posedge clk or negedge seqResetN) begin
		if (!seqResetN) begin
			cpuResetN <= 1'b0;
			vectorFetch <= 1'b0;
			vectorAddr <= `CRS_VECTOR_ADDR;
		end else begin
			cpuResetN <= inCorePhase(state_q);
			vectorFetch <= (state_q == ST_FETCH);
			vectorAddr <= `CRS_VECTOR_ADDR + {14'h0, fetchCnt_q};
		end
	end

	// ****************************************
	// Oscillator trim
	// ****************************************
	always @(posedge clk or negedge seqResetN) begin
		if (!seqResetN) begin
			trimBits <= `CRS_RC_TRIM_RESET;
		end else begin
			trimBits <= trim_q;
		end
	end

	// ****************************************
	// Oscillator source and crystal
	// ****************************************
	// The crystal keeps running through reset so its start-up is not repeated
	always @(posedge clk or negedge seqResetN) begin
		if (!seqResetN) begin
			oscSource <= `CRS_SRC_RC;
			xtalRun <= 1'b1;
		end else begin
			oscSource <= oscSelect(rcEnable, xtalSelect);
			xtalRun <= xtalSelect;
		end
	end

	// ****************************************
	// Main PLL
	// ****************************************
	// The PLL clock stays gated until the start-up wait has run out
	always @(posedge clk or negedge seqResetN) begin
		if (!seqResetN) begin
			pllMultiply8 <= 1'b0;
			pllRun <= 1'b0;
			pllClockGate <= 1'b0;
		end else begin
			pllMultiply8 <= pllTimes8;
			pllRun <= pllEnable;
			pllClockGate <= pllEnable & inCorePhase(state_q);
		end
	end

	// ****************************************
	// Timer PLL and external clock pin
	// ****************************************
	always @(posedge clk or negedge seqResetN) begin
		if (!seqResetN) begin
			timerPllRun <= 1'b0;
			defaultExtClockPin <= 1'b1;
		end else begin
			timerPllRun <= timerPllEnable;
			defaultExtClockPin <= ~multiOscUsed;
		end
	end

	// ****************************************
	// CPU clock gate and clock output
	// ****************************************
	// In slow mode one cycle in 32 passes, always at the divider wrap
	always @(posedge clk or negedge seqResetN) begin
		if (!seqResetN) begin
			cpuClockEnable <= 1'b0;
			clockOutEnable <= 1'b0;
		end else begin
			cpuClockEnable <= (state_q == ST_RUN) & (~slowActive_q | boundary);
			clockOutEnable <= ctrl_q[`CRS_CLOCK_OUT_ENABLE_BIT];
		end
	end
endmodule

//--- crs_clock_reset_seq_tb_top.sv
// Self-checking bench for the clock and reset sequencer
`timescale 1ns/1ps
module crs_clock_reset_seq_tb_top;
	logic clk = 0, nrst = 0, cyc = 0, we = 0, wd = 0, lv = 0, ext = 0, mo = 0, tp = 0;
	logic rcEn = 1, pllEn = 0, xtal = 0, lock = 0, ack, oe, cce, cko, vf, pin, tpr, dep, xr;
	logic [7:0] adr = 0, trim, lfsr = 8'h21;
	logic [31:0] di = 0, dOut, rd;
	logic [1:0] src;
	int num_errors = 0, num_checks = 0, n, i, m[4];
	always #12.5 clk = ~clk;
	crs_ext_reset crs_ext_reset_inst (.pullLow(ext), .devPullLow(oe), .pinLevel(pin));
	crs_clock_reset_seq #(.PLL_STARTUP_CYCLES(8), .LONG_DELAY(32)) crs_clock_reset_seq_inst (
		.clk(clk), .nrst(nrst), .wbCyc(cyc), .wbStb(cyc), .wbWe(we), .wbAdr(adr),
		.wbSel(4'h1), .wbDatI(di), .wbDatO(dOut), .wbAck(ack), .rcEnable(rcEn),
		.pllEnable(pllEn), .pllTimes8(1'b1), .xtalSelect(xtal), .multiOscUsed(mo),
		.timerPllEnable(tp), .lowVoltageReset(lv), .watchdogReset(wd), .resetPinIn(pin),
		.resetPinOut(), .resetPinOe(oe), .pllLockRaw(lock), .trimBits(trim), .oscSource(src),
		.pllMultiply8(), .pllRun(), .pllClockGate(), .timerPllRun(tpr),
		.defaultExtClockPin(dep), .xtalRun(xr), .cpuClockEnable(cce), .clockOutEnable(cko),
		.cpuResetN(), .vectorFetch(vf),
		.vectorAddr());
	function logic [7:0] nxt(input logic [7:0] l);
		return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
	endfunction
	task test_done;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s exp %h seen %h", s, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1;
		we <= w;
		adr <= a;
		di <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = dOut;
		cyc <= 0;
		chk("ack", 1, n < 50);
		if (n >= 50) test_done();
		if (w && a == 8'h00) m[0] = d & 3;
		if (w && a == 8'h04) m[1] = d & 8'hff;
		@(posedge clk);
	endtask
	task rdm(input logic [7:0] a);
		bus(0, a, 0);
		chk("reg", m[a[3:2]], rd);
	endtask
	task rst(input int s);
		wd <= s == 0;
		lv <= s == 1;
		ext <= s == 2;
		if (s < 3) repeat (4) @(posedge clk);
		wd <= 0;
		lv <= 0;
		ext <= 0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (vf !== 1'b1 && n < 400);
		i = (xtal ? 32 : 256) + (pllEn ? 8 : 0);
		chk("delay", 1, n >= i && n <= i + 8);
		if (n >= 400) test_done();
		m[0] = 0;
		m[1] = 8'hff;
		repeat (4) @(posedge clk);
	endtask
	task cnt(input int e);
		n = 0;
		repeat (64) begin
			@(posedge clk);
			n += cce;
		end
		chk("cpuClk", e, n);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1;
		rst(3);
		rdm(8'h00);
		rdm(8'h04);
		for (i = 0; i < 4; i++) begin
			lfsr = nxt(lfsr);
			bus(1, 8'h04, {24'h0, lfsr});
			rdm(8'h04);
			chk("trimBits", lfsr, trim);
		end
		bus(0, 8'h10, 0);
		chk("unmapped", 0, rd);
		chk("rcSrc", 2'h0, src);
		chk("extPin", 1, dep);
		chk("timerPll", 0, tpr);
		bus(1, 8'h00, 32'hff);
		rdm(8'h00);
		repeat (40) @(posedge clk);
		cnt(2);
		bus(1, 8'h00, 2);
		repeat (40) @(posedge clk);
		cnt(64);
		chk("clkOut", 1, cko);
		rst(0);
		rdm(8'h00);
		rdm(8'h04);
		chk("clkOut", 0, cko);
		xtal <= 1;
		pllEn <= 1;
		lock <= 1;
		rst(1);
		chk("xtalRun", 1, xr);
		bus(1, 8'h08, 0);
		bus(0, 8'h08, 0);
		chk("lock", 1, rd[3]);
		rcEn <= 0;
		xtal <= 0;
		pllEn <= 0;
		mo <= 1;
		tp <= 1;
		rst(2);
		chk("extSrc", 2'h1, src);
		chk("extPin", 0, dep);
		chk("timerPll", 1, tpr);
		bus(0, 8'h08, 0);
		chk("lock", 0, rd[3]);
		test_done();
	end
endmodule

//--- crs_ext_reset.sv
// External reset circuit on the open-drain reset line
`timescale 1ns/1ps
module crs_ext_reset (
	// Pull-down requests
	input wire pullLow,
	input wire devPullLow,
	// Line level
	output wire pinLevel
);
	// Weak pull-up: a released line reads high
	assign pinLevel = !(pullLow || devPullLow);
endmodule

//--- crs_seq_props.sv
// Port checker for the clock and reset sequencer
`timescale 1ns/1ps
module crs_seq_props (
	// System
	input wire clk,
	input wire nrst,
	// Options and sources
	input wire rcEnable,
	input wire pllEnable,
	input wire xtalSelect,
	input wire watchdogReset,
	// Outputs
	input wire resetPinOe,
	input wire [7:0] trimBits,
	input wire [1:0] oscSource,
	input wire clockOutEnable,
	input wire cpuClockEnable,
	input wire cpuResetN,
	input wire vectorFetch,
	input wire [15:0] vectorAddr
);
	// ****
	// Checks
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	trim_reset_a:
		assert property ($rose(resetPinOe) |-> trimBits == 8'hff) else $error("trim kept");
	ctrl_reset_a:
		assert property ($rose(resetPinOe) |-> !clockOutEnable) else $error("clock out kept");
	wd_pin_a:
		assert property (watchdogReset |-> resetPinOe) else $error("pin free");
	fetch_len_a:
		assert property ($rose(vectorFetch) |-> vectorFetch[*2] ##1 !vectorFetch) else $error("fetch");
	vec_addr_a:
		assert property ($rose(vectorFetch) |-> vectorAddr == 16'hfffe ##1 vectorAddr == 16'hffff)
			else $error("vector");
	phase_order_a:
		assert property (vectorFetch |-> !resetPinOe) else $error("order");
	slow_gap_a:
		assert property (cpuClockEnable ##1 !cpuClockEnable |=> !cpuClockEnable[*8]) else $error("gap");
	rc_source_a:
		assert property (cpuResetN && rcEnable && !pllEnable && !xtalSelect |-> oscSource == 2'h0)
			else $error("source");
	cover property ($rose(vectorFetch));
	cover property (cpuClockEnable ##1 !cpuClockEnable);
	cover property (clockOutEnable && cpuResetN);
endmodule
bind crs_clock_reset_seq crs_seq_props crs_seq_props_inst (.clk(clk), .nrst(nrst),
	.rcEnable(rcEnable), .pllEnable(pllEnable), .xtalSelect(xtalSelect),
	.watchdogReset(watchdogReset), .resetPinOe(resetPinOe), .trimBits(trimBits),
	.oscSource(oscSource), .clockOutEnable(clockOutEnable), .cpuClockEnable(cpuClockEnable),
	.cpuResetN(cpuResetN), .vectorFetch(vectorFetch), .vectorAddr(vectorAddr));

//--- crs_seq_regs.vh
// Register map, field positions, reset values and timing counts of the clock and reset sequencer
`ifndef CRS_SEQ_REGS_VH
`define CRS_SEQ_REGS_VH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CRS_MAIN_CLOCK_CTRL_ADDR 8'h00
`define CRS_RC_TRIM_ADDR 8'h04
`define CRS_SYS_INTEGRITY_STATUS_ADDR 8'h08
`define CRS_OPTIONS_ADDR 8'h0c
// ****************************************
// Fields and reset values
// ****************************************
`define CRS_SLOW_MODE_SELECT_BIT 0
`define CRS_CLOCK_OUT_ENABLE_BIT 1
`define CRS_LOCKED_BIT 3
`define CRS_MAIN_CLOCK_CTRL_RESET 8'h00
`define CRS_RC_TRIM_RESET 8'hff
`define CRS_SLOW_DIVIDE 6'h20
// ****************************************
// Oscillator source encodings (option bits)
// ****************************************
`define CRS_SRC_RC 2'h0
`define CRS_SRC_EXT 2'h1
`define CRS_SRC_XTAL 2'h2
// ****************************************
// Timing counts
// ****************************************
`define CRS_DELAY_SHORT 13'h0100
`define CRS_DELAY_LONG 13'h1000
`define CRS_FETCH_CYCLES 2'h2
`define CRS_VECTOR_ADDR 16'hfffe
`define CRS_PLL_STARTUP_US 16'h0064
`define CRS_CLK_MHZ 16'h0028
`endif
